//--- port_ef_regs.vh
`ifndef PORT_EF_REGS_VH
`define PORT_EF_REGS_VH

// ==========================================================
// Register byte offsets on the Avalon-MM slave
// ==========================================================
`define OFS_PORT_E_LEVELS 8'h00
`define OFS_PORT_E_LATCH 8'h04
`define OFS_PORT_E_DIR 8'h08
`define OFS_PORT_G_PULLUPS 8'h0c
`define OFS_PORT_F_LEVELS 8'h10
`define OFS_PORT_F_LATCH 8'h14
`define OFS_PORT_F_DIR 8'h18
`define OFS_WATCHDOG_CTRL 8'h1c
`define OFS_COMPARATOR_CTRL 8'h20
`define OFS_PIN_SELECT_CFG 8'h24
`define OFS_SHARED_LOW 8'h28
`define OFS_SHARED_HIGH 8'h2c

// ==========================================================
// Field positions
// ==========================================================
`define BIT_SHARED_WINDOW 4
`define BIT_PULLUP_D 7
`define BIT_PULLUP_E 6
`define BIT_PULLUP_J 5
`define BIT_COMP1_EN 0
`define BIT_COMP2_EN 1
`define BIT_COMP1_OUT_EN 2
`define BIT_COMP2_OUT_EN 3
`define BIT_PWM_UNIT_SEL 0
`define BIT_SECOND_CAP_SEL 1
`define BIT_HOST_PORT_SEL 2

// ==========================================================
// Reset values
// ==========================================================
`define RST_LATCH 8'h00
`define RST_DIR 8'hff
`define RST_F_LATCH 7'h00
`define RST_F_DIR 7'h7f
`define RST_PULLUPS 3'h0
`define RST_WATCHDOG 1'h0
`define RST_COMPARATOR 4'h0
`define RST_PIN_SELECT 3'h7
`define RST_ANALOG_SELECT 8'h00
`define RST_SHARED_ALT 8'h00

// ==========================================================
// Timing counts (cycles of the 10 MHz clock)
// ==========================================================
`define SYNC_STAGES 2
`define BUS_ACK_CYCLES 1

`endif

//--- pin_sync.v
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser for asynchronous pin levels
// ==========================================================
module pin_sync #(
  parameter WIDTH = 10
) (
  input wire clk_in,
  input wire rstn_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // First stage feeds only the second stage, never any logic
  always @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;

endmodule

`default_nettype wire

//--- port_ef_mux.v
// How it works
// - External bus, when active, beats every other digital function on a pin.
// - Upper E pins 5-7 carry external bus bits 13-15, both directions.
// - Upper E pins 5-7 drive host address lines 11,10,9 regardless of direction.
// - Routed PWM output beats latch and host address when direction bit is 0.
// - PWM pins may float during a shutdown event when so configured.
// - Second capture pin: direction 0 drives compare, direction 1 feeds capture.
// - Bus and host-port functions ignore the direction bit.
// - First PWM channels B,C use default pins when select set, large package.
// - Second capture and PWM A move to pin E7 when select cleared, MCU mode.
// - Host strobes stay on default pins while host select is 1.
// - Small package reads the missing pull-up enable bit as zero.
// - Port F is seven bits wide with per-pin direction control.
// - Port F pins 1-6 can be analog channels; pin 7 cannot.
// - After reset pins F1-F6 are analog and read as zero.
// - Comparator control assigns port F pins as comparator inputs or outputs.
// - Host select 0 puts host data lines on port F, large package only.
// - Analog-select registers share addresses, decoded by the window bit.
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "port_ef_regs.vh"

module port_ef_mux #(
  parameter LARGE_PACKAGE = 1
) (
  input wire REF_CLK_IN,
  input wire RSTN_IN,
  input wire [7:0] AVS_ADDRESS_IN,
  input wire AVS_READ_IN,
  input wire AVS_WRITE_IN,
  input wire [31:0] AVS_WRITEDATA_IN,
  input wire [3:0] AVS_BYTEENABLE_IN,
  output reg [31:0] AVS_READDATA_OUT,
  output wire AVS_WAITREQUEST_OUT,
  input wire MCU_MODE_IN,
  input wire EXT_BUS_EN_IN,
  input wire EXT_BUS_OE_IN,
  input wire [2:0] EXT_BUS_AD_IN,
  output reg [2:0] EXT_BUS_AD_OUT,
  input wire [2:0] HOST_ADDR_EN_IN,
  input wire [2:0] HOST_ADDR_IN,
  input wire HOST_DATA_EN_IN,
  input wire HOST_DATA_OE_IN,
  input wire [2:0] HOST_DATA_IN,
  output reg [2:0] HOST_DATA_OUT,
  output wire HOST_STROBE_DEFAULT_PINS_OUT,
  input wire [2:0] PWM_EN_IN,
  input wire [2:0] PWM_VALUE_IN,
  input wire PWM_SHUTDOWN_IN,
  input wire [2:0] PWM_SHUTDOWN_TRI_IN,
  input wire CCP2_COMPARE_EN_IN,
  input wire CCP2_COMPARE_IN,
  output reg CCP2_CAPTURE_OUT,
  input wire COMP1_RESULT_IN,
  input wire COMP2_RESULT_IN,
  input wire [2:0] PORT_E_PIN_IN,
  output reg [2:0] PORT_E_PIN_OUT,
  output reg [2:0] PORT_E_PIN_OE_N_OUT,
  input wire [7:1] PORT_F_PIN_IN,
  output reg [7:1] PORT_F_PIN_OUT,
  output reg [7:1] PORT_F_PIN_OE_N_OUT,
  output wire [6:1] ANALOG_MODE_OUT,
  output wire PULLUP_D_OUT,
  output wire PULLUP_E_OUT,
  output wire PULLUP_J_OUT
);

  // ========================================================
  // Software-visible state
  // ========================================================
  reg [7:0] port_e_output_latch;
  reg [7:0] port_e_direction;
  reg [7:1] port_f_output_latch;
  reg [7:1] port_f_direction;
  reg [2:0] pullup_enable;
  reg shared_register_window_select;
  reg [3:0] comparator_control;
  reg [2:0] pin_select_cfg;
  reg [7:0] analog_select_low;
  reg [7:0] analog_select_high;
  reg [7:0] shared_alt_low;
  reg [7:0] shared_alt_high;
  reg bus_ack;
  reg [7:0] next_read_byte;
  reg [2:0] next_e_out;
  reg [2:0] next_e_drive;
  reg [7:1] next_f_out;
  reg [7:1] next_f_drive;
  wire [7:1] f_digital_ok;
  integer k;
  integer j;

  wire [9:0] pins_sync;
  wire [2:0] e_sync;
  wire [7:1] f_sync;
  wire bus_req;
  wire bus_take;
  wire wr_lane0;
  wire large_pkg;
  wire pwm_unit_pin_select;
  wire second_capture_pin_select;
  wire host_port_pin_select;
  wire ext_bus_on;
  wire ccp2_routed;
  wire host_data_on;
  wire [2:0] pwm_routed;

  // ========================================================
  // Pin synchronisers
  // ========================================================
  // One shared instance keeps all pins on equal latency
  pin_sync #(.WIDTH(10)) u_pin_sync (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in({PORT_F_PIN_IN, PORT_E_PIN_IN}),
    .sync_out(pins_sync)
  );

  assign e_sync = pins_sync[2:0];
  assign f_sync = pins_sync[9:3];

  // ========================================================
  // Configuration decode
  // ========================================================
  assign large_pkg = (LARGE_PACKAGE != 0);
  assign pwm_unit_pin_select = pin_select_cfg[`BIT_PWM_UNIT_SEL];
  assign second_capture_pin_select = pin_select_cfg[`BIT_SECOND_CAP_SEL];
  assign host_port_pin_select = pin_select_cfg[`BIT_HOST_PORT_SEL];
  // Address/data lines exist only on the large package
  assign ext_bus_on = large_pkg & EXT_BUS_EN_IN;
  // PWM1 B/C on pins E6/E5 only in the large package
  assign pwm_routed[0] = large_pkg & pwm_unit_pin_select & PWM_EN_IN[0];
  assign pwm_routed[1] = large_pkg & pwm_unit_pin_select & PWM_EN_IN[1];
  // Alternate capture pin E7 in any package, MCU mode
  assign ccp2_routed = ~second_capture_pin_select & MCU_MODE_IN;
  assign pwm_routed[2] = ccp2_routed & PWM_EN_IN[2];
  assign host_data_on = large_pkg & ~host_port_pin_select &
                        HOST_DATA_EN_IN;
  assign HOST_STROBE_DEFAULT_PINS_OUT = host_port_pin_select;
  // Zero select bit means analog; reset leaves F1-F6 analog
  assign ANALOG_MODE_OUT = {~analog_select_high[3:0],
                            ~analog_select_low[7:6]};
  assign PULLUP_D_OUT = pullup_enable[2];
  assign PULLUP_E_OUT = pullup_enable[1];
  assign PULLUP_J_OUT = pullup_enable[0] & large_pkg;

  // ========================================================
  // Port E upper pins: priority mux
  // ========================================================
  // Bit k of each group belongs to pin E(5+k)
  always @*
  begin
    next_e_out = 3'h0;
    next_e_drive = 3'h0;
    for (k = 0; k < 3; k = k + 1)
    begin
      if (ext_bus_on)
      begin
        // Bus direction alone decides, direction bit ignored
        next_e_out[k] = EXT_BUS_AD_IN[k];
        next_e_drive[k] = EXT_BUS_OE_IN;
      end
      else if (pwm_routed[k] && !port_e_direction[5+k])
      begin
        // Shutdown may float the pin instead of driving it
        next_e_out[k] = PWM_VALUE_IN[k];
        next_e_drive[k] = ~(PWM_SHUTDOWN_IN &
                            PWM_SHUTDOWN_TRI_IN[k]);
      end
      else if (HOST_ADDR_EN_IN[k])
      begin
        next_e_out[k] = HOST_ADDR_IN[k];
        next_e_drive[k] = 1'b1;
      end
      else if (k == 2 && ccp2_routed && CCP2_COMPARE_EN_IN &&
               !port_e_direction[7])
      begin
        next_e_out[k] = CCP2_COMPARE_IN;
        next_e_drive[k] = 1'b1;
      end
      else
      begin
        next_e_out[k] = port_e_output_latch[5+k];
        next_e_drive[k] = ~port_e_direction[5+k];
      end
    end
  end

  // ========================================================
  // Port F pins: host data, comparator outputs, GPIO
  // ========================================================
  // Host data lines 2,1,0 sit on pins F5,F6,F7
  always @*
  begin
    next_f_out = 7'h00;
    next_f_drive = 7'h00;
    for (j = 1; j < 8; j = j + 1)
    begin
      if (host_data_on && j >= 5)
      begin
        next_f_out[j] = HOST_DATA_IN[7-j];
        next_f_drive[j] = HOST_DATA_OE_IN;
      end
      else if (j == 1 && comparator_control[`BIT_COMP2_OUT_EN])
      begin
        next_f_out[j] = COMP2_RESULT_IN;
        next_f_drive[j] = 1'b1;
      end
      else if (j == 2 && comparator_control[`BIT_COMP1_OUT_EN])
      begin
        next_f_out[j] = COMP1_RESULT_IN;
        next_f_drive[j] = 1'b1;
      end
      else
      begin
        // Analog mode leaves the output driver alone
        next_f_out[j] = port_f_output_latch[j];
        next_f_drive[j] = ~port_f_direction[j];
      end
    end
  end

  // Digital read gating; comparators claim F3-F6, F7 is never analog
  assign f_digital_ok = {1'b1,
    analog_select_high[3:2] & ~{2{comparator_control[`BIT_COMP1_EN]}},
    analog_select_high[1:0] & ~{2{comparator_control[`BIT_COMP2_EN]}},
    analog_select_low[7:6]};

  // ========================================================
  // Registered pin and peripheral outputs
  // ========================================================
  // Registering costs a cycle but keeps pads glitch free
  always @(posedge REF_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      PORT_E_PIN_OUT <= 3'h0;
      PORT_E_PIN_OE_N_OUT <= 3'h7;
      PORT_F_PIN_OUT <= 7'h00;
      PORT_F_PIN_OE_N_OUT <= 7'h7f;
      EXT_BUS_AD_OUT <= 3'h0;
      HOST_DATA_OUT <= 3'h0;
      CCP2_CAPTURE_OUT <= 1'b0;
    end
    else
    begin
      PORT_E_PIN_OUT <= next_e_out;
      PORT_E_PIN_OE_N_OUT <= ~next_e_drive;
      PORT_F_PIN_OUT <= next_f_out;
      PORT_F_PIN_OE_N_OUT <= ~next_f_drive;
      EXT_BUS_AD_OUT <= e_sync;
      HOST_DATA_OUT <= {f_sync[5], f_sync[6], f_sync[7]};
      CCP2_CAPTURE_OUT <= ccp2_routed & port_e_direction[7] &
                          e_sync[2];
    end
  end

  // ========================================================
  // Avalon-MM slave: one wait cycle per access
  // ========================================================
  assign bus_req = AVS_READ_IN | AVS_WRITE_IN;
  assign AVS_WAITREQUEST_OUT = bus_req & ~bus_ack;
  // The access completes on the edge with waitrequest low
  assign bus_take = bus_req & bus_ack;
  assign wr_lane0 = bus_take & AVS_WRITE_IN & AVS_BYTEENABLE_IN[0];

  // Read mux; unmapped offsets read zero
  always @*
  begin
    case (AVS_ADDRESS_IN)
      `OFS_PORT_E_LEVELS: next_read_byte = {e_sync, 5'h00};
      `OFS_PORT_E_LATCH: next_read_byte = port_e_output_latch;
      `OFS_PORT_E_DIR: next_read_byte = port_e_direction;
      `OFS_PORT_G_PULLUPS:
        next_read_byte = {pullup_enable[2:1],
                          pullup_enable[0] & large_pkg,
                          5'h00};
      `OFS_PORT_F_LEVELS:
        next_read_byte = {f_sync & f_digital_ok, 1'b0};
      `OFS_PORT_F_LATCH: next_read_byte = {port_f_output_latch, 1'b0};
      `OFS_PORT_F_DIR: next_read_byte = {port_f_direction, 1'b0};
      `OFS_WATCHDOG_CTRL:
        next_read_byte = {3'h0, shared_register_window_select, 4'h0};
      `OFS_COMPARATOR_CTRL: next_read_byte = {4'h0, comparator_control};
      `OFS_PIN_SELECT_CFG: next_read_byte = {5'h00, pin_select_cfg};
      `OFS_SHARED_LOW:
        next_read_byte = shared_register_window_select ?
                         analog_select_low : shared_alt_low;
      `OFS_SHARED_HIGH:
        next_read_byte = shared_register_window_select ?
                         analog_select_high : shared_alt_high;
      default: next_read_byte = 8'h00;
    endcase
  end

  // Handshake and read data capture
  always @(posedge REF_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      bus_ack <= 1'b0;
      AVS_READDATA_OUT <= 32'h00000000;
    end
    else
    begin
      bus_ack <= bus_req & ~bus_ack;
      if (AVS_READ_IN && !bus_ack)
        AVS_READDATA_OUT <= {24'h000000, next_read_byte};
    end
  end

  // Register writes through byte lane 0
  always @(posedge REF_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      port_e_output_latch <= `RST_LATCH;
      port_e_direction <= `RST_DIR;
      port_f_output_latch <= `RST_F_LATCH;
      port_f_direction <= `RST_F_DIR;
      pullup_enable <= `RST_PULLUPS;
      shared_register_window_select <= `RST_WATCHDOG;
      comparator_control <= `RST_COMPARATOR;
      pin_select_cfg <= `RST_PIN_SELECT;
      analog_select_low <= `RST_ANALOG_SELECT;
      analog_select_high <= `RST_ANALOG_SELECT;
      shared_alt_low <= `RST_SHARED_ALT;
      shared_alt_high <= `RST_SHARED_ALT;
    end
    else if (wr_lane0)
    begin
      case (AVS_ADDRESS_IN)
        // Writing the level register lands in the latch
        `OFS_PORT_E_LEVELS, `OFS_PORT_E_LATCH:
          port_e_output_latch <= AVS_WRITEDATA_IN[7:0];
        `OFS_PORT_E_DIR: port_e_direction <= AVS_WRITEDATA_IN[7:0];
        `OFS_PORT_G_PULLUPS:
          pullup_enable <= AVS_WRITEDATA_IN[7:5];
        `OFS_PORT_F_LEVELS, `OFS_PORT_F_LATCH:
          port_f_output_latch <= AVS_WRITEDATA_IN[7:1];
        `OFS_PORT_F_DIR:
          port_f_direction <= AVS_WRITEDATA_IN[7:1];
        `OFS_WATCHDOG_CTRL:
          shared_register_window_select <=
            AVS_WRITEDATA_IN[`BIT_SHARED_WINDOW];
        `OFS_COMPARATOR_CTRL:
          comparator_control <= AVS_WRITEDATA_IN[3:0];
        `OFS_PIN_SELECT_CFG: pin_select_cfg <= AVS_WRITEDATA_IN[2:0];
        `OFS_SHARED_LOW:
          if (shared_register_window_select)
            analog_select_low <= AVS_WRITEDATA_IN[7:0];
          else
            shared_alt_low <= AVS_WRITEDATA_IN[7:0];
        `OFS_SHARED_HIGH:
          if (shared_register_window_select)
            analog_select_high <= AVS_WRITEDATA_IN[7:0];
          else
            shared_alt_high <= AVS_WRITEDATA_IN[7:0];
        default: ;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- port_ef_mux_unused.v
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

//--- port_ef_mux_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Pin priority checker
// ==========================================================
module port_ef_mux_chk #(
  parameter LARGE_PACKAGE = 1
) (
  input wire REF_CLK_IN,
  input wire RSTN_IN,
  input wire [7:0] AVS_ADDRESS_IN,
  input wire AVS_WRITE_IN,
  input wire [31:0] AVS_WRITEDATA_IN,
  input wire [3:0] AVS_BYTEENABLE_IN,
  input wire AVS_WAITREQUEST_OUT,
  input wire MCU_MODE_IN,
  input wire EXT_BUS_EN_IN,
  input wire EXT_BUS_OE_IN,
  input wire [2:0] EXT_BUS_AD_IN,
  input wire [2:0] HOST_ADDR_EN_IN,
  input wire [2:0] HOST_ADDR_IN,
  input wire [2:0] PWM_EN_IN,
  input wire [2:0] PWM_VALUE_IN,
  input wire PWM_SHUTDOWN_IN,
  input wire [2:0] PWM_SHUTDOWN_TRI_IN,
  input wire CCP2_COMPARE_EN_IN,
  input wire CCP2_COMPARE_IN,
  input wire [2:0] PORT_E_PIN_OUT,
  input wire [2:0] PORT_E_PIN_OE_N_OUT,
  input wire [7:1] PORT_F_PIN_OE_N_OUT,
  input wire [6:1] ANALOG_MODE_OUT
);
  reg [7:0] e_dir;
  reg [7:0] f_dir;
  reg [2:0] sel;
  wire wr_done;

  // Mirror of direction and pin-select, so checks know the pin setup
  assign wr_done = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT
    & AVS_BYTEENABLE_IN[0];
  always @(posedge REF_CLK_IN)
  begin
    if (!RSTN_IN)
    begin
      e_dir <= 8'hff;
      f_dir <= 8'hff;
      sel <= 3'h7;
    end
    else if (wr_done)
    begin
      if (AVS_ADDRESS_IN == 8'h08) e_dir <= AVS_WRITEDATA_IN[7:0];
      if (AVS_ADDRESS_IN == 8'h18) f_dir <= AVS_WRITEDATA_IN[7:0];
      if (AVS_ADDRESS_IN == 8'h24) sel <= AVS_WRITEDATA_IN[2:0];
    end
  end

  // ==========================================================
  // Properties, one edge after the mux inputs, except a_reset_analog and the three covers (same edge)
  // ==========================================================
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  a_ext_bus_wins:
    assert property (LARGE_PACKAGE != 0 && EXT_BUS_EN_IN && EXT_BUS_OE_IN
      |=> PORT_E_PIN_OE_N_OUT == 3'h0
      && PORT_E_PIN_OUT == $past(EXT_BUS_AD_IN))
    else $error("bus value not on pins");
  a_host_addr_out:
    assert property (!EXT_BUS_EN_IN && HOST_ADDR_EN_IN == 3'h7
      && (PWM_EN_IN == 3'h0 || e_dir[7:5] == 3'h7)
      |=> PORT_E_PIN_OE_N_OUT == 3'h0
      && PORT_E_PIN_OUT == $past(HOST_ADDR_IN))
    else $error("host address not on pins");
  a_pwm_over_port:
    assert property (!EXT_BUS_EN_IN && PWM_EN_IN[1] && !PWM_SHUTDOWN_IN
      && !e_dir[6] && sel[0] && LARGE_PACKAGE != 0
      |=> !PORT_E_PIN_OE_N_OUT[1]
      && PORT_E_PIN_OUT[1] == $past(PWM_VALUE_IN[1]))
    else $error("pwm channel b not on pin");
  a_shutdown_float:
    assert property (!EXT_BUS_EN_IN && PWM_EN_IN[1] && PWM_SHUTDOWN_IN
      && PWM_SHUTDOWN_TRI_IN[1] && !e_dir[6] && sel[0] && LARGE_PACKAGE != 0
      |=> PORT_E_PIN_OE_N_OUT[1])
    else $error("pin driven during shutdown");
  a_compare_on_e7:
    assert property (!EXT_BUS_EN_IN && !PWM_EN_IN[2] && !HOST_ADDR_EN_IN[2]
      && CCP2_COMPARE_EN_IN && !e_dir[7] && !sel[1] && MCU_MODE_IN
      |=> !PORT_E_PIN_OE_N_OUT[2]
      && PORT_E_PIN_OUT[2] == $past(CCP2_COMPARE_IN))
    else $error("compare result not on pin");
  a_idle_e_dir:
    assert property (!EXT_BUS_EN_IN && !PWM_EN_IN[0] && !HOST_ADDR_EN_IN[0]
      |=> PORT_E_PIN_OE_N_OUT[0] == $past(e_dir[5]))
    else $error("idle pin ignores direction");
  a_f_dir_follows:
    assert property (PORT_F_PIN_OE_N_OUT[4] == $past(f_dir[4]))
    else $error("port pin ignores direction");
  a_reset_analog:
    assert property ($rose(RSTN_IN) |-> ANALOG_MODE_OUT == 6'h3f)
    else $error("pins not analog after reset");

  c_ext_bus: cover property (EXT_BUS_EN_IN && EXT_BUS_OE_IN);
  c_shutdown: cover property (PWM_SHUTDOWN_IN && PWM_SHUTDOWN_TRI_IN[1]);
  c_compare: cover property (CCP2_COMPARE_EN_IN && !sel[1] && !e_dir[7]);
endmodule

bind port_ef_mux port_ef_mux_chk #(.LARGE_PACKAGE(LARGE_PACKAGE)) chk_u (
  .REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN),
  .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
  .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
  .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN),
  .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .MCU_MODE_IN(MCU_MODE_IN),
  .EXT_BUS_EN_IN(EXT_BUS_EN_IN), .EXT_BUS_OE_IN(EXT_BUS_OE_IN),
  .EXT_BUS_AD_IN(EXT_BUS_AD_IN), .HOST_ADDR_EN_IN(HOST_ADDR_EN_IN),
  .HOST_ADDR_IN(HOST_ADDR_IN), .PWM_EN_IN(PWM_EN_IN),
  .PWM_VALUE_IN(PWM_VALUE_IN), .PWM_SHUTDOWN_IN(PWM_SHUTDOWN_IN),
  .PWM_SHUTDOWN_TRI_IN(PWM_SHUTDOWN_TRI_IN),
  .CCP2_COMPARE_EN_IN(CCP2_COMPARE_EN_IN),
  .CCP2_COMPARE_IN(CCP2_COMPARE_IN), .PORT_E_PIN_OUT(PORT_E_PIN_OUT),
  .PORT_E_PIN_OE_N_OUT(PORT_E_PIN_OE_N_OUT),
  .PORT_F_PIN_OE_N_OUT(PORT_F_PIN_OE_N_OUT),
  .ANALOG_MODE_OUT(ANALOG_MODE_OUT)
);
`default_nettype wire

//--- port_ef_board.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Board: straps hold each released pin at a fixed level
// ==========================================================
module port_ef_board (
  input wire logic [2:0] e_out_in,
  input wire logic [2:0] e_oe_n_in,
  input wire logic [7:1] f_out_in,
  input wire logic [7:1] f_oe_n_in,
  input wire logic [2:0] e_strap_in,
  input wire logic [7:1] f_strap_in,
  output logic [2:0] e_pin_out,
  output logic [7:1] f_pin_out
);
  // Block wins where its enable is low, strap elsewhere
  assign e_pin_out = (e_out_in & ~e_oe_n_in) | (e_strap_in & e_oe_n_in);
  assign f_pin_out = (f_out_in & ~f_oe_n_in) | (f_strap_in & f_oe_n_in);
endmodule
`default_nettype wire

//--- port_ef_mux_tb.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Testbench
// ==========================================================
module port_ef_mux_tb;
  logic clk, rstn, rd, wr, mcu, ext_en, ext_oe, hd_en, hd_oe, shut;
  logic cc_en, cc, c1, c2;
  logic [7:0] addr;
  logic [31:0] wdata, q;
  logic [2:0] ext_ad, ha_en, ha, hd, pwm_en, pwm_v, tri_en;
  wire [31:0] rdata;
  wire waitreq, strobe_def, cap, pu_d, pu_e, pu_j;
  wire [2:0] ad_out, hd_out, e_out, e_oe_n, e_pin;
  wire [7:1] f_out, f_oe_n, f_pin;
  wire [6:1] analog;
  integer failures, samples_checked;

  port_ef_mux dut_u (
    .REF_CLK_IN(clk), .RSTN_IN(rstn), .AVS_ADDRESS_IN(addr),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(4'h1), .AVS_READDATA_OUT(rdata),
    .AVS_WAITREQUEST_OUT(waitreq), .MCU_MODE_IN(mcu),
    .EXT_BUS_EN_IN(ext_en), .EXT_BUS_OE_IN(ext_oe),
    .EXT_BUS_AD_IN(ext_ad), .EXT_BUS_AD_OUT(ad_out),
    .HOST_ADDR_EN_IN(ha_en), .HOST_ADDR_IN(ha), .HOST_DATA_EN_IN(hd_en),
    .HOST_DATA_OE_IN(hd_oe), .HOST_DATA_IN(hd), .HOST_DATA_OUT(hd_out),
    .HOST_STROBE_DEFAULT_PINS_OUT(strobe_def), .PWM_EN_IN(pwm_en),
    .PWM_VALUE_IN(pwm_v), .PWM_SHUTDOWN_IN(shut),
    .PWM_SHUTDOWN_TRI_IN(tri_en), .CCP2_COMPARE_EN_IN(cc_en),
    .CCP2_COMPARE_IN(cc), .CCP2_CAPTURE_OUT(cap),
    .COMP1_RESULT_IN(c1), .COMP2_RESULT_IN(c2),
    .PORT_E_PIN_IN(e_pin), .PORT_E_PIN_OUT(e_out),
    .PORT_E_PIN_OE_N_OUT(e_oe_n), .PORT_F_PIN_IN(f_pin),
    .PORT_F_PIN_OUT(f_out), .PORT_F_PIN_OE_N_OUT(f_oe_n),
    .ANALOG_MODE_OUT(analog), .PULLUP_D_OUT(pu_d), .PULLUP_E_OUT(pu_e),
    .PULLUP_J_OUT(pu_j)
  );
  port_ef_board board_u (
    .e_out_in(e_out), .e_oe_n_in(e_oe_n), .f_out_in(f_out),
    .f_oe_n_in(f_oe_n), .e_strap_in(3'b101), .f_strap_in(7'b1010101),
    .e_pin_out(e_pin), .f_pin_out(f_pin)
  );

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task tally_and_finish;
  begin
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  task check(input [31:0] got, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask

  task ticks(input integer n);
    repeat (n) @(posedge clk);
  endtask

  // One transfer; request held to the rising edge that sees waitrequest low
  task xfer(input r, input [7:0] a, input [7:0] d);
    integer n;
  begin
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= r;
    wr <= !r;
    n = 0;
    @(posedge clk);
    while (waitreq !== 1'b0 && n < 20)
    begin
      n = n + 1;
      @(posedge clk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    check({31'h0, n == 20}, 32'h0);
    if (n == 20)
      tally_and_finish;
  end
  endtask

  task rd_chk(input [7:0] a, input [7:0] exp);
  begin
    xfer(1'b1, a, 8'h00);
    check(q, {24'h0, exp});
  end
  endtask

  // Port E pins after the mux has settled
  task pe(input [2:0] o, input [2:0] n);
  begin
    ticks(3);
    check({26'h0, e_oe_n, e_out}, {26'h0, n, o});
  end
  endtask

  // Hang guard, well past the expected run of about 150 cycles
  initial
  begin
    #(100 * 4000);
    failures = failures + 1;
    tally_and_finish;
  end

  initial
  begin
    failures = 0;
    samples_checked = 0;
    {rstn, rd, wr, ext_en, ext_oe, hd_en, hd_oe, shut, cc_en, cc, c1} = 0;
    {ext_ad, ha_en, ha, hd, pwm_en, pwm_v, tri_en} = 0;
    addr = 8'h00;
    wdata = 32'h0;
    mcu = 1'b1;
    c2 = 1'b1;
    ticks(20);
    rstn <= 1'b1;
    // Pin levels need two edges to clear the synchronisers
    ticks(2);
    rd_chk(8'h10, 8'h80);
    rd_chk(8'h00, 8'ha0);
    rd_chk(8'h08, 8'hff);
    rd_chk(8'h24, 8'h07);
    rd_chk(8'h30, 8'h00);
    xfer(1'b0, 8'h28, 8'h5a);
    ticks(1);
    check({26'h0, analog}, 32'h3f);
    xfer(1'b0, 8'h1c, 8'h10);
    xfer(1'b0, 8'h28, 8'hc0);
    xfer(1'b0, 8'h2c, 8'h0f);
    xfer(1'b0, 8'h1c, 8'h00);
    check({26'h0, analog}, 32'h0);
    rd_chk(8'h28, 8'h5a);
    rd_chk(8'h10, 8'haa);
    xfer(1'b0, 8'h20, 8'h02);
    rd_chk(8'h10, 8'ha2);
    xfer(1'b0, 8'h20, 8'h0f);
    ticks(2);
    check({23'h0, f_oe_n, f_out[2:1]}, {23'h0, 7'h7c, 2'b01});
    xfer(1'b0, 8'h20, 8'h00);
    xfer(1'b0, 8'h18, 8'hce);
    xfer(1'b0, 8'h14, 8'h30);
    ticks(4);
    check({25'h0, f_oe_n}, 32'h67);
    rd_chk(8'h10, 8'hba);
    xfer(1'b0, 8'h24, 8'h03);
    hd_en <= 1'b1;
    hd_oe <= 1'b1;
    hd <= 3'b110;
    ticks(3);
    check({25'h0, strobe_def, f_oe_n[7:5], f_out[7:5]}, 32'h3);
    hd_oe <= 1'b0;
    ticks(5);
    check({29'h0, hd_out}, 32'h5);
    hd_en <= 1'b0;
    xfer(1'b0, 8'h24, 8'h07);
    // Port E, stepping down the priority ladder
    {ext_en, ext_oe, ext_ad, ha_en, ha} <= {2'b11, 3'b010, 3'h7, 3'b001};
    {pwm_en, pwm_v, cc_en, cc} <= {3'h7, 3'b100, 2'b10};
    pe(3'b010, 3'h0);
    ext_oe <= 1'b0;
    ticks(5);
    check({26'h0, e_oe_n, ad_out}, 32'h3d);
    ext_en <= 1'b0;
    pe(3'b001, 3'h0);
    xfer(1'b0, 8'h04, 8'hc0);
    xfer(1'b0, 8'h08, 8'h1f);
    xfer(1'b0, 8'h24, 8'h05);
    pe(3'b100, 3'h0);
    shut <= 1'b1;
    tri_en <= 3'b011;
    ticks(3);
    check({28'h0, e_oe_n, e_out[2]}, 32'h7);
    shut <= 1'b0;
    xfer(1'b0, 8'h24, 8'h04);
    pe(3'b101, 3'h0);
    pwm_en <= 3'h0;
    ha_en <= 3'h0;
    pe(3'b010, 3'h0);
    // Outside MCU mode E7 falls back to its latch
    mcu <= 1'b0;
    pe(3'b110, 3'h0);
    mcu <= 1'b1;
    xfer(1'b0, 8'h08, 8'hff);
    ticks(5);
    check({28'h0, e_oe_n, cap}, 32'hf);
    cc_en <= 1'b0;
    xfer(1'b0, 8'h0c, 8'he0);
    rd_chk(8'h0c, 8'he0);
    check({29'h0, pu_d, pu_e, pu_j}, 32'h7);
    tally_and_finish;
  end
endmodule
`default_nettype wire
